// *** inc/entropy_seed_pkg.sv ***
// Shared constants and types for the entropy polling register block
`default_nettype none
package entropy_seed_pkg;
   localparam logic [11:0] POLL_CSR_ADDR  = 12'h015;
   localparam int          CSR_ADDR_W     = 12;
   localparam int          WORD_W         = 32;
   localparam int          ENTROPY_W      = 16;
   localparam int          RESV_W         = 6;
   localparam int          CUSTOM_W       = 8;
   localparam int          SRC_W          = 5;
   localparam int          MSECCFG_W      = 32;
   localparam int          SSEED_BIT      = 9;
   localparam int          USEED_BIT      = 8;
   localparam logic [RESV_W-1:0]    RESV_VALUE    = 6'h00;
   localparam logic [CUSTOM_W-1:0]  CUSTOM_VALUE  = 8'h00;
   localparam logic [ENTROPY_W-1:0] ENTROPY_ZERO  = 16'h0000;
   localparam logic [WORD_W-1:0]    WORD_ZERO     = 32'h0000_0000;
   localparam logic [SRC_W-1:0]     SRC_ZERO      = 5'h00;
   localparam int          BUF_DEPTH      = 2;
   localparam int          BUF_PTR_W      = 1;
   localparam int          BUF_CNT_W      = 2;
   localparam logic [BUF_PTR_W-1:0] PTR_ZERO  = 1'h0;
   localparam logic [BUF_PTR_W-1:0] PTR_ONE   = 1'h1;
   localparam logic [BUF_CNT_W-1:0] CNT_ZERO  = 2'h0;
   localparam logic [BUF_CNT_W-1:0] CNT_ONE   = 2'h1;
   localparam logic [BUF_CNT_W-1:0] CNT_FULL  = 2'h2;

   typedef enum logic [1:0] {
      OP_SELF_TEST = 2'b00,
      OP_WAIT      = 2'b01,
      OP_READY     = 2'b10,
      OP_DEAD      = 2'b11
   } op_status_type;

   typedef enum logic [1:0] {
      CSR_NONE = 2'b00,
      CSR_RW   = 2'b01,
      CSR_RS   = 2'b10,
      CSR_RC   = 2'b11
   } csr_op_type;

   typedef enum logic [1:0] {
      PRIV_U   = 2'b00,
      PRIV_S   = 2'b01,
      PRIV_RSV = 2'b10,
      PRIV_M   = 2'b11
   } priv_type;
endpackage
`default_nettype wire

// *** design/entropy_word_buffer.sv ***
// Two-entry buffer between the noise source and the holding register
`default_nettype none
module entropy_word_buffer (
   input  wire logic                                   i_clk,
   input  wire logic                                   i_rst_b,
   input  wire logic                                   i_in_valid,
   input  wire logic [entropy_seed_pkg::ENTROPY_W-1:0] i_in_data,
   output logic                                        o_in_ready,
   output logic                                        o_out_valid,
   output logic      [entropy_seed_pkg::ENTROPY_W-1:0] o_out_data,
   input  wire logic                                   i_out_ready
);
   logic [entropy_seed_pkg::ENTROPY_W-1:0] mem_r [entropy_seed_pkg::BUF_DEPTH];
   logic [entropy_seed_pkg::BUF_PTR_W-1:0] wr_ptr_r;
   logic [entropy_seed_pkg::BUF_PTR_W-1:0] rd_ptr_r;
   logic [entropy_seed_pkg::BUF_CNT_W-1:0] count_r;
   logic [entropy_seed_pkg::BUF_CNT_W-1:0] count_nxt;
   wire                                    push;
   wire                                    pop;

   assign o_in_ready  = (count_r != entropy_seed_pkg::CNT_FULL);
   assign o_out_valid = (count_r != entropy_seed_pkg::CNT_ZERO);
   assign o_out_data  = mem_r[rd_ptr_r];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   // Count moves only when exactly one side fires
   assign count_nxt   = (push && !pop) ? count_r + entropy_seed_pkg::CNT_ONE :
                        (pop && !push) ? count_r - entropy_seed_pkg::CNT_ONE : count_r;

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         wr_ptr_r <= entropy_seed_pkg::PTR_ZERO;
         rd_ptr_r <= entropy_seed_pkg::PTR_ZERO;
         count_r  <= entropy_seed_pkg::CNT_ZERO;
         mem_r[0] <= entropy_seed_pkg::ENTROPY_ZERO;
         mem_r[1] <= entropy_seed_pkg::ENTROPY_ZERO;
      end else begin
         if (push) begin
            mem_r[wr_ptr_r] <= i_in_data;
            wr_ptr_r        <= wr_ptr_r + entropy_seed_pkg::PTR_ONE;
         end
         if (pop) begin
            // Wipe a consumed slot so no secret lingers in storage
            mem_r[rd_ptr_r] <= entropy_seed_pkg::ENTROPY_ZERO;
            rd_ptr_r        <= rd_ptr_r + entropy_seed_pkg::PTR_ONE;
         end
         count_r <= count_nxt;
      end
   end
endmodule
`default_nettype wire

// *** design/entropy_access_check.sv ***
// Access form and privilege check for the entropy polling register
`default_nettype none
module entropy_access_check (
   input  wire logic                                   i_valid,
   input  wire logic [1:0]                             i_op,
   input  wire logic [entropy_seed_pkg::SRC_W-1:0]     i_src,
   input  wire logic [1:0]                             i_priv,
   input  wire logic [entropy_seed_pkg::MSECCFG_W-1:0] i_mseccfg,
   output logic                                        o_allowed,
   output logic                                        o_illegal
);
   logic form_ok;
   logic mode_ok;

   // Set or clear with a zero source is read only and must trap
   always_comb begin
      form_ok = 1'b0;
      unique case (entropy_seed_pkg::csr_op_type'(i_op))
         entropy_seed_pkg::CSR_RW: form_ok = 1'b1; // [R04]
         entropy_seed_pkg::CSR_RS: form_ok = (i_src != entropy_seed_pkg::SRC_ZERO); // [R04]
         entropy_seed_pkg::CSR_RC: form_ok = (i_src != entropy_seed_pkg::SRC_ZERO); // [R04]
         default:                  form_ok = 1'b0;
      endcase
   end

   // Lower modes need their grant bit; the reserved mode never gets one
   always_comb begin
      mode_ok = 1'b0;
      unique case (entropy_seed_pkg::priv_type'(i_priv))
         entropy_seed_pkg::PRIV_M:   mode_ok = 1'b1; // [R06]
         entropy_seed_pkg::PRIV_S:   mode_ok = i_mseccfg[entropy_seed_pkg::SSEED_BIT]; // [R19]
         entropy_seed_pkg::PRIV_U:   mode_ok = i_mseccfg[entropy_seed_pkg::USEED_BIT]; // [R19]
         entropy_seed_pkg::PRIV_RSV: mode_ok = 1'b0; // [R06]
      endcase
   end

   assign o_allowed = i_valid && form_ok && mode_ok;
   assign o_illegal = i_valid && !(form_ok && mode_ok);
endmodule
`default_nettype wire

// *** design/entropy_seed_csr_poll.sv ***
// Entropy polling control register with self-test state tracking
// Notes on behaviour
// [R01] Register decoded at control address 0x015
// [R02] Status 31:30, reserved 29:24, custom 23:16, entropy 15:0
// [R03] Status 10 success, 11 dead
// [R04] Read-only set/clear forms trap as illegal
// [R05] Written data ignored, no stored value changes
// [R06] Below machine mode, trap unless access granted
// [R07] Each successful poll returns fresh sixteen bits
// [R08] Entropy field zero unless status is success
// [R09] Reserved and custom bits read as zero
// [R10] Successful poll wipes word, waits unless next ready
// [R11] Polls leave self-test, wait, dead unchanged
// [R12] Status 00 self-test; re-entry flags non-fatal alarm
// [R13] Alarm holds self-test until polled once
// [R14] Status 01 waiting, a normal condition
// [R15] Fatal failure enters dead, reports 11 forever
// [R16] Self-test only after reset or alarm
// [R17] Normally alternate between wait and ready
// [R18] Software polls with read-write, source x0
// [R19] Grant bits: supervisor bit 9, user bit 8
// [R20] Accept source words by handshake, hold one
// [R21] Self-test after reset until start-up tests end
`default_nettype none
module entropy_seed_csr_poll (
   input  wire logic                                    I_MCLK,
   input  wire logic                                    I_RST_B,
   input  wire logic                                    I_CSR_VALID,
   input  wire logic [entropy_seed_pkg::CSR_ADDR_W-1:0] I_CSR_ADDR,
   input  wire logic [1:0]                              I_CSR_OP,
   input  wire logic [entropy_seed_pkg::SRC_W-1:0]      I_CSR_SRC,
   input  wire logic [entropy_seed_pkg::WORD_W-1:0]     I_CSR_WDATA,
   input  wire logic [1:0]                              I_PRIV,
   input  wire logic [entropy_seed_pkg::MSECCFG_W-1:0]  I_MSECCFG,
   output logic                                         O_CSR_RVALID,
   output logic      [entropy_seed_pkg::WORD_W-1:0]     O_CSR_RDATA,
   output logic                                         O_CSR_ILLEGAL,
   input  wire logic                                    I_NOISE_VALID,
   input  wire logic [entropy_seed_pkg::ENTROPY_W-1:0]  I_NOISE_DATA,
   output logic                                         O_NOISE_READY,
   input  wire logic                                    I_HT_BUSY,
   input  wire logic                                    I_HT_ALARM,
   input  wire logic                                    I_HT_FATAL,
   output logic      [1:0]                              O_OP_STATUS,
   output logic                                         O_ENTROPY_READY,
   output logic                                         O_ALARM_PENDING,
   output logic                                         O_LOCKDOWN
);
   entropy_seed_pkg::op_status_type state_r;
   entropy_seed_pkg::op_status_type state_nxt;

   logic [entropy_seed_pkg::ENTROPY_W-1:0] hold_data_r;
   logic [entropy_seed_pkg::ENTROPY_W-1:0] hold_data_nxt;
   logic                                   hold_valid_r;
   logic                                   hold_valid_nxt;
   logic                                   alarm_r;
   logic                                   alarm_nxt;
   logic                                   rvalid_r;
   logic                                   illegal_r;
   logic [entropy_seed_pkg::WORD_W-1:0]    rdata_r;
   logic [entropy_seed_pkg::WORD_W-1:0]    rdata_nxt;

   wire                                    buf_valid;
   wire  [entropy_seed_pkg::ENTROPY_W-1:0] buf_data;
   wire                                    buf_ready;
   wire                                    access_ok;
   wire                                    access_bad;
   wire                                    poll_hit;
   wire                                    poll_ok;
   wire                                    poll_ready;
   wire                                    in_normal;
   wire                                    alarm_in;
   wire                                    wipe;
   wire                                    load;
   wire                                    alarm_clear;
   wire  [entropy_seed_pkg::ENTROPY_W-1:0] ret_entropy;
   wire  [entropy_seed_pkg::WORD_W-1:0]    unused_wdata;

   function automatic logic [entropy_seed_pkg::WORD_W-1:0] pack_word(
      input logic [1:0]                             status,
      input logic [entropy_seed_pkg::ENTROPY_W-1:0] value
   );
      pack_word = {status,
                   entropy_seed_pkg::RESV_VALUE,
                   entropy_seed_pkg::CUSTOM_VALUE,
                   value}; // [R02] [R09]
   endfunction

   entropy_word_buffer u_buffer (
      .i_clk       (I_MCLK),
      .i_rst_b     (I_RST_B),
      .i_in_valid  (I_NOISE_VALID),
      .i_in_data   (I_NOISE_DATA),
      .o_in_ready  (O_NOISE_READY),
      .o_out_valid (buf_valid),
      .o_out_data  (buf_data),
      .i_out_ready (buf_ready)
   );

   entropy_access_check u_access (
      .i_valid   (poll_hit),
      .i_op      (I_CSR_OP),
      .i_src     (I_CSR_SRC),
      .i_priv    (I_PRIV),
      .i_mseccfg (I_MSECCFG),
      .o_allowed (access_ok),
      .o_illegal (access_bad)
   );

   // Write data has no destination here; polling is the only effect
   assign unused_wdata = I_CSR_WDATA; // [R05]

   assign poll_hit   = I_CSR_VALID && (I_CSR_ADDR == entropy_seed_pkg::POLL_CSR_ADDR); // [R01]
   assign poll_ok    = poll_hit && access_ok; // [R04] [R06]
   assign poll_ready = poll_ok && (state_r == entropy_seed_pkg::OP_READY);
   assign in_normal  = (state_r == entropy_seed_pkg::OP_WAIT) ||
                       (state_r == entropy_seed_pkg::OP_READY);

   // Alarms only count from the normal states; elsewhere they are absorbed
   assign alarm_in    = I_HT_ALARM && in_normal; // [R12] [R16]
   assign wipe        = alarm_in || I_HT_FATAL || (state_r == entropy_seed_pkg::OP_DEAD);
   assign alarm_clear = poll_ok && (state_r == entropy_seed_pkg::OP_SELF_TEST); // [R13]

   // Refill in the same cycle as a consuming poll keeps the ready state
   assign load      = in_normal && !wipe && buf_valid &&
                      (!hold_valid_r || poll_ready); // [R20] [R10]
   assign buf_ready = load; // [R20]

   assign hold_valid_nxt = wipe       ? 1'b0 :
                           load       ? 1'b1 :
                           poll_ready ? 1'b0 : hold_valid_r; // [R10]
   assign hold_data_nxt  = load               ? buf_data :
                           (wipe||poll_ready) ? entropy_seed_pkg::ENTROPY_ZERO :
                                                hold_data_r; // [R10] [R07]

   // New alarm beats a clearing poll if both ever coincide
   assign alarm_nxt = alarm_in || (alarm_r && !alarm_clear); // [R13]

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         entropy_seed_pkg::OP_SELF_TEST: begin
            // Move to wait only when tests are idle and any alarm was seen by software
            if (!I_HT_BUSY && !alarm_r) begin
               state_nxt = entropy_seed_pkg::OP_WAIT; // [R21] [R13]
            end
         end
         entropy_seed_pkg::OP_WAIT: begin
            if (alarm_in) begin
               state_nxt = entropy_seed_pkg::OP_SELF_TEST; // [R12] [R16]
            end else if (load) begin
               state_nxt = entropy_seed_pkg::OP_READY; // [R17]
            end
         end
         entropy_seed_pkg::OP_READY: begin
            if (alarm_in) begin
               state_nxt = entropy_seed_pkg::OP_SELF_TEST; // [R12] [R16]
            end else if (poll_ready && !load) begin
               state_nxt = entropy_seed_pkg::OP_WAIT; // [R10] [R17] [R14]
            end
         end
         entropy_seed_pkg::OP_DEAD: begin
            state_nxt = entropy_seed_pkg::OP_DEAD; // [R15] [R11]
         end
      endcase
      if (I_HT_FATAL) begin
         state_nxt = entropy_seed_pkg::OP_DEAD; // [R15]
      end
   end

   // Entropy leaves the block only with the success code
   assign ret_entropy = poll_ready ? hold_data_r : entropy_seed_pkg::ENTROPY_ZERO; // [R08] [R07]
   assign rdata_nxt   = access_ok ? pack_word(state_r, ret_entropy) :
                                    entropy_seed_pkg::WORD_ZERO; // [R03] [R14]

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_B) begin
         state_r <= entropy_seed_pkg::OP_SELF_TEST; // [R21] [R16]
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_B) begin
         hold_valid_r <= 1'b0;
         hold_data_r  <= entropy_seed_pkg::ENTROPY_ZERO;
         alarm_r      <= 1'b0;
      end else begin
         hold_valid_r <= hold_valid_nxt;
         hold_data_r  <= hold_data_nxt;
         alarm_r      <= alarm_nxt;
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_B) begin
         rvalid_r  <= 1'b0;
         illegal_r <= 1'b0;
         rdata_r   <= entropy_seed_pkg::WORD_ZERO;
      end else begin
         rvalid_r  <= poll_hit;
         illegal_r <= access_bad; // [R04] [R06] [R19]
         rdata_r   <= poll_hit ? rdata_nxt : entropy_seed_pkg::WORD_ZERO;
      end
   end

   assign O_CSR_RVALID    = rvalid_r;
   assign O_CSR_RDATA     = rdata_r;
   assign O_CSR_ILLEGAL   = illegal_r;
   assign O_OP_STATUS     = state_r;
   assign O_ENTROPY_READY = (state_r == entropy_seed_pkg::OP_READY);
   assign O_ALARM_PENDING = alarm_r;
   // Lockdown request for parts that must shut down on a fatal failure
   assign O_LOCKDOWN      = (state_r == entropy_seed_pkg::OP_DEAD); // [R15]
endmodule
`default_nettype wire

// *** testbench/entropy_seed_chk.sv ***
// Port checker for the entropy polling register
`default_nettype none
module entropy_seed_chk (
   input  wire logic        I_MCLK,
   input  wire logic        I_RST_B,
   input  wire logic        I_CSR_VALID,
   input  wire logic [11:0] I_CSR_ADDR,
   input  wire logic [1:0]  I_CSR_OP,
   input  wire logic [4:0]  I_CSR_SRC,
   input  wire logic [1:0]  I_PRIV,
   input  wire logic [31:0] I_MSECCFG,
   input  wire logic        I_HT_ALARM,
   input  wire logic        I_HT_FATAL,
   input  wire logic        O_CSR_RVALID,
   input  wire logic [31:0] O_CSR_RDATA,
   input  wire logic        O_CSR_ILLEGAL,
   input  wire logic [1:0]  O_OP_STATUS,
   input  wire logic        O_ALARM_PENDING
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_B);
   wire logic hit;
   assign hit = I_CSR_VALID && I_CSR_ADDR == 12'h015;
   ans_one_a:
      assert property (hit |=> O_CSR_RVALID) else $error("no answer after access");
   no_ans_a:
      assert property (!hit |=> !O_CSR_RVALID && !O_CSR_ILLEGAL) else $error("stray answer");
   ent_zero_a:
      assert property (O_CSR_RVALID && O_CSR_RDATA[31:30] != 2'h2
         |-> O_CSR_RDATA[15:0] == 16'h0000) else $error("entropy bits without success");
   resv_zero_a:
      assert property (O_CSR_RVALID |-> O_CSR_RDATA[29:16] == 14'h0000)
         else $error("reserved or custom bits set");
   ro_trap_a:
      assert property (hit && I_CSR_OP[1] && I_CSR_SRC == 5'h00 |=> O_CSR_ILLEGAL)
         else $error("read-only form not trapped");
   mode_trap_a:
      assert property (hit && (I_PRIV == 2'h0 && !I_MSECCFG[8]
         || I_PRIV == 2'h1 && !I_MSECCFG[9]) |=> O_CSR_ILLEGAL && O_CSR_RDATA == 32'h0)
         else $error("ungranted mode not trapped");
   fatal_dead_a:
      assert property (I_HT_FATAL |=> O_OP_STATUS == 2'h3) else $error("fatal not dead");
   dead_stay_a:
      assert property (O_OP_STATUS == 2'h3 |=> $stable(O_OP_STATUS)) else $error("left dead");
   alarm_retest_a:
      assert property (I_HT_ALARM && !I_HT_FATAL && O_OP_STATUS inside {2'h1, 2'h2}
         |=> O_OP_STATUS == 2'h0 && O_ALARM_PENDING) else $error("alarm not latched");
   pend_hold_a:
      assert property (O_ALARM_PENDING |-> O_OP_STATUS inside {2'h0, 2'h3})
         else $error("left self-test with alarm pending");
endmodule
bind entropy_seed_csr_poll entropy_seed_chk u_chk (.I_MCLK, .I_RST_B, .I_CSR_VALID,
   .I_CSR_ADDR, .I_CSR_OP, .I_CSR_SRC, .I_PRIV, .I_MSECCFG, .I_HT_ALARM, .I_HT_FATAL,
   .O_CSR_RVALID, .O_CSR_RDATA, .O_CSR_ILLEGAL, .O_OP_STATUS, .O_ALARM_PENDING);
`default_nettype wire

// *** testbench/noise_src_model.sv ***
// Noise source model offering numbered words by valid and ready
`default_nettype none
module noise_src_model (
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_go,
   input  wire logic        i_ready,
   output logic             o_valid,
   output logic      [15:0] o_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] seq_r;
   // Inverted off-handshake so a stale word never passes as data
   assign o_data = o_valid ? seq_r : ~seq_r;
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_valid <= 1'b0;
         seq_r   <= 16'hA001;
      end else if (o_valid && i_ready) begin
         o_valid <= i_go;
         seq_r   <= seq_r + 16'h0001;
      end else if (!o_valid) begin
         o_valid <= i_go;
      end
   end
endmodule
`default_nettype wire

// *** testbench/entropy_seed_csr_poll_bench.sv ***
// Directed bench for the entropy polling register
`default_nettype none
module entropy_seed_csr_poll_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst_b, valid, nv, nr, busy, alarm, fatal, go;
   logic        rvalid, ill, ready, pend, lock;
   logic [11:0] addr;
   logic [1:0]  op, priv, st;
   logic [4:0]  src;
   logic [31:0] cfg, rdata;
   logic [15:0] nd;
   int          mismatches, checks;

   entropy_seed_csr_poll u_dut (.I_MCLK(clk), .I_RST_B(rst_b), .I_CSR_VALID(valid),
      .I_CSR_ADDR(addr), .I_CSR_OP(op), .I_CSR_SRC(src), .I_CSR_WDATA(32'hFFFF_FFFF),
      .I_PRIV(priv), .I_MSECCFG(cfg), .O_CSR_RVALID(rvalid), .O_CSR_RDATA(rdata),
      .O_CSR_ILLEGAL(ill), .I_NOISE_VALID(nv), .I_NOISE_DATA(nd), .O_NOISE_READY(nr),
      .I_HT_BUSY(busy), .I_HT_ALARM(alarm), .I_HT_FATAL(fatal), .O_OP_STATUS(st),
      .O_ENTROPY_READY(ready), .O_ALARM_PENDING(pend), .O_LOCKDOWN(lock));
   noise_src_model u_src (.i_clk(clk), .i_rst_b(rst_b), .i_go(go), .i_ready(nr),
      .o_valid(nv), .o_data(nd));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      if (mismatches == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One access; answer is sampled in its single valid cycle
   task automatic poll(input logic [1:0] o, input logic [4:0] s, input logic [1:0] p,
                       input logic [31:0] c, input logic [11:0] a, input logic [33:0] e);
      @(posedge clk);
      valid <= 1'b1;
      op    <= o;
      src   <= s;
      priv  <= p;
      cfg   <= c;
      addr  <= a;
      @(posedge clk);
      valid <= 1'b0;
      #1 chk({rvalid, ill, rdata}, e);
   endtask

   initial begin
      repeat (3000) @(posedge clk);
      mismatches++;
      report_and_stop;
   end

   initial begin
      {rst_b, valid, alarm, fatal, op, src, priv, cfg, addr} = '0;
      {busy, go} = 2'b11;
      mismatches = 0;
      checks = 0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
      go <= 1'b0;
      // Buffer full and stalling while self-test holds
      #1 chk(34'({st, nr, ready}), 34'h0);
      poll(2'h1, 5'h00, 2'h3, 32'h0, 12'h015, 34'h2_0000_0000);
      @(posedge clk) busy <= 1'b0;
      for (int i = 0; i < 20 && ready !== 1'b1; i++) @(posedge clk);
      #1 chk(34'({st, ready}), 34'h5);
      // Refused accesses answer flagged, a miss at 0x014 gets no answer; none may consume the held word
      poll(2'h2, 5'h00, 2'h3, 32'h0, 12'h015, 34'h3_0000_0000);
      poll(2'h3, 5'h00, 2'h3, 32'h0, 12'h015, 34'h3_0000_0000);
      poll(2'h0, 5'h01, 2'h3, 32'h0, 12'h015, 34'h3_0000_0000);
      poll(2'h1, 5'h00, 2'h0, 32'h200, 12'h015, 34'h3_0000_0000);
      poll(2'h1, 5'h00, 2'h1, 32'h100, 12'h015, 34'h3_0000_0000);
      poll(2'h1, 5'h00, 2'h2, 32'h300, 12'h015, 34'h3_0000_0000);
      poll(2'h1, 5'h00, 2'h3, 32'h0, 12'h014, 34'h0_0000_0000);
      poll(2'h2, 5'h05, 2'h0, 32'h100, 12'h015, 34'h2_8000_A001);
      poll(2'h3, 5'h03, 2'h1, 32'h200, 12'h015, 34'h2_8000_A002);
      poll(2'h1, 5'h00, 2'h3, 32'h0, 12'h015, 34'h2_8000_A003);
      poll(2'h1, 5'h00, 2'h3, 32'h0, 12'h015, 34'h2_4000_0000);
      @(posedge clk) alarm <= 1'b1;
      @(posedge clk) alarm <= 1'b0;
      #1 chk(34'({st, pend}), 34'h1);
      repeat (4) @(posedge clk);
      #1 chk(34'({st, pend}), 34'h1);
      poll(2'h1, 5'h00, 2'h3, 32'h0, 12'h015, 34'h2_0000_0000);
      repeat (2) @(posedge clk);
      #1 chk(34'({st, pend}), 34'h2);
      @(posedge clk) fatal <= 1'b1;
      @(posedge clk) fatal <= 1'b0;
      poll(2'h1, 5'h00, 2'h3, 32'h0, 12'h015, 34'h2_C000_0000);
      chk(34'({st, lock}), 34'h7);
      report_and_stop;
   end
endmodule
`default_nettype wire
